/* apms_consts.svh */
`ifndef APMS_CONSTS_SVH
`define APMS_CONSTS_SVH

// Result and frame geometry
`define APMS_RES_W 12
`define APMS_FIFO_DEPTH 8
`define APMS_CNT_W 6

// Serial clock falling-edge thresholds counted from select fall
`define APMS_GLITCH_EDGES 6'h02
`define APMS_KEEP_EDGES 6'h0A
`define APMS_TRACK_EDGES 6'h0D
`define APMS_LAST_DATA_EDGE 6'h0D
`define APMS_RESULT_EDGES 6'h0E
`define APMS_TRAIL_EDGES 6'h10
`define APMS_SECOND_FIRST_EDGE 6'h12
`define APMS_SECOND_LAST_EDGE 6'h1D
`define APMS_DUAL_EDGES 6'h20

// Timing: figures in their own unit, cycle counts derived from the clock
`define APMS_CLK_PERIOD_PS 10000
`define APMS_PART_WAKE_PS 333000
`define APMS_PART_WAKE_CYC ((`APMS_PART_WAKE_PS + `APMS_CLK_PERIOD_PS - 1) / `APMS_CLK_PERIOD_PS)
`define APMS_FULL_WAKE_MS 6
// Worked in ns over the period in ns so no 32-bit intermediate overflows
`define APMS_FULL_WAKE_CYC ((`APMS_FULL_WAKE_MS * 1000000) / (`APMS_CLK_PERIOD_PS / 1000))
`define APMS_WAKE_W 20

`endif

/* apms_pkg.sv */
`include "apms_consts.svh"

package apms_pkg;

  // Power state, one-hot
  typedef enum logic [2:0] {
    APMS_NORMAL = 3'h1,
    APMS_PARTIAL = 3'h2,
    APMS_FULL = 3'h4
  } apms_mode_e;

  // Both converter results of one sample instant
  typedef struct packed {
    logic [`APMS_RES_W-1:0] first;
    logic [`APMS_RES_W-1:0] second;
  } apms_pair_s;

  // One serial output pin, output enable low while driving
  typedef struct packed {
    logic data;
    logic oe_n;
  } apms_line_s;

  // Sequencer state
  typedef struct packed {
    apms_mode_e mode;
    logic in_frame;
    logic [`APMS_CNT_W-1:0] fall_cnt;
    apms_pair_s words;
    apms_line_s line_first;
    apms_line_s line_second;
    logic pop;
    logic conv_start;
    logic track;
    logic waking;
    logic wake_from_full;
    logic [`APMS_WAKE_W-1:0] wake_cnt;
    logic power_ready;
  } apms_seq_s;

endpackage : apms_pkg

/* apms_sync.sv */
`timescale 1ns/1ps

module apms_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Asynchronous inputs
  input wire logic [W-1:0] async_i,
  // Synchronised level and edge pulses
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] prev;
  } apms_sync_s;

  apms_sync_s s;
  apms_sync_s next_s;

  // Two stages before use; edges look only at the settled stages
  always_comb begin
    next_s = s;
    next_s.meta = async_i;
    next_s.stable = s.meta;
    next_s.prev = s.stable;
  end

  // Idle high so no edge is seen at reset release
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign level_o = s.stable;
  assign rise_o = s.stable & ~s.prev;
  assign fall_o = ~s.stable & s.prev;

endmodule : apms_sync

/* apms_fifo.sv */
`timescale 1ns/1ps

module apms_fifo #(
  parameter int W = 24,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic room;
  } apms_fifo_s;

  apms_fifo_s s;
  apms_fifo_s next_s;
  logic push;
  logic pop;

  // Empty comes from the count; room is registered so ready leaves a flop
  assign in_ready_o = s.room;
  assign out_valid_o = (s.count != '0);
  assign out_data_o = s.mem[s.rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointers wrap at the depth, which need not be a power of two
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr_ptr] = in_data_i;
      next_s.wr_ptr = (s.wr_ptr == AW'(D - 1)) ? '0 : s.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_s.rd_ptr = (s.rd_ptr == AW'(D - 1)) ? '0 : s.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_s.count = s.count + 1'b1;
    end else if (pop && !push) begin
      next_s.count = s.count - 1'b1;
    end
    next_s.room = (next_s.count != (AW+1)'(D));
  end

  // State register
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '{mem: '0, wr_ptr: '0, rd_ptr: '0, count: '0, room: 1'b1};
    end else begin
      s <= next_s;
    end
  end

endmodule : apms_fifo

/* apms_sequencer.sv */
// Operation
// RULE_01: Host holds select past 10 falls to stay powered
// RULE_02: Rise in falls 10..13 aborts, stays powered, floats
// RULE_03: Full result readout needs 14 serial clocks
// RULE_04: After 14 clocks lines drive until select rises
// RULE_05: Two more clocks give two trailing zeros
// RULE_06: Further 14 clocks give other converter's result
// RULE_07: Active line floats at 32nd fall or rise
// RULE_08: Host waits quiet gap and acquisition before next
// RULE_09: Normal, rise in falls 2..9 enters partial
// RULE_10: Normal, rise before 2nd fall keeps normal
// RULE_11: Dummy conversion past 10 falls wakes partial
// RULE_12: Partial, rise before 2nd fall stays partial
// RULE_13: Wake starts at fall, undone by early rise
// RULE_14: Partial, rise in falls 2..9 enters full
// RULE_15: Host need not finish clocks after power-down
// RULE_16: Full wake: dummy conversion then about 6 ms
// RULE_17: Host keeps quiet gap after partial wake
// RULE_18: Waking sampler tracks after first clock edge; code does so only from partial, from full not until select rise
// RULE_19: Host runs one dummy cycle after power-on
// RULE_20: Two dummy cycles for partial after power-on
// RULE_21: Three dummy cycles for full after power-on
// RULE_22: Host limits partial power-down to 100 us
// RULE_23: Count falls from select fall, judge at rise
// RULE_24: Two leading zeros, 12 bits, last at 14th
// RULE_25: Second line carries first result second half
// RULE_26: Select fall samples, starts conversions, drives lines
`timescale 1ns/1ps
`include "apms_consts.svh"

module apms_sequencer #(
  parameter int FULL_WAKE_DELAY_CYC = `APMS_FULL_WAKE_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Serial pins from the host
  input wire logic conv_sel_n_i,
  input wire logic serial_clk_i,
  // Serial data pins
  output apms_pkg::apms_line_s serial_out_first_o,
  output apms_pkg::apms_line_s serial_out_second_o,
  // Results from the two converters
  input wire logic res_valid_i,
  output logic res_ready_o,
  input wire apms_pkg::apms_pair_s res_data_i,
  // Converter control
  output logic conv_start_o,
  output logic track_o,
  output apms_pkg::apms_mode_e power_mode_o,
  output logic power_ready_o
);

  localparam logic [`APMS_WAKE_W-1:0] PART_WAKE = `APMS_WAKE_W'(`APMS_PART_WAKE_CYC);
  localparam logic [`APMS_WAKE_W-1:0] FULL_WAKE = `APMS_WAKE_W'(FULL_WAKE_DELAY_CYC);

  apms_pkg::apms_seq_s s;
  apms_pkg::apms_seq_s next_s;
  logic [1:0] rst_sync;
  logic rst_n;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;
  logic sel_rise;
  logic sel_fall;
  logic clk_rise;
  logic clk_fall;
  logic fifo_valid;
  apms_pkg::apms_pair_s fifo_data;
  logic [`APMS_CNT_W-1:0] cnt_inc;

  // Bit driven after c serial clock falls: zeros, word a, zeros, word b
  function automatic logic frame_bit(input logic [`APMS_CNT_W-1:0] c,
                                     input logic [`APMS_RES_W-1:0] a,
                                     input logic [`APMS_RES_W-1:0] b);
    logic [`APMS_CNT_W-1:0] idx;
    logic bit_out;
    idx = '0;
    bit_out = 1'b0;
    if (c >= `APMS_GLITCH_EDGES && c <= `APMS_LAST_DATA_EDGE) begin // RULE_03
      idx = `APMS_LAST_DATA_EDGE - c; // RULE_24
      bit_out = a[idx[3:0]];
    end else if (c >= `APMS_SECOND_FIRST_EDGE && c <= `APMS_SECOND_LAST_EDGE) begin
      idx = `APMS_SECOND_LAST_EDGE - c; // RULE_06
      bit_out = b[idx[3:0]];
    end
    return bit_out;
  endfunction : frame_bit

  // Reset released through two flip-flops
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Pins cross into the clock domain; index 1 is select, 0 the serial clock
  apms_sync #(
    .W(2)
  ) u_sync (
    .clock_i(clock_i),
    .rstn_i(rst_n),
    .async_i({conv_sel_n_i, serial_clk_i}),
    .level_o(),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  assign sel_rise = pin_rise[1];
  assign sel_fall = pin_fall[1];
  assign clk_rise = pin_rise[0];
  assign clk_fall = pin_fall[0];

  // Results queue until a select fall claims them
  apms_fifo #(
    .W($bits(apms_pkg::apms_pair_s)),
    .D(`APMS_FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rstn_i(rst_n),
    .in_valid_i(res_valid_i),
    .in_ready_o(res_ready_o),
    .in_data_i(res_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(s.pop),
    .out_data_o(fifo_data)
  );

  assign cnt_inc = s.fall_cnt + 1'b1;

  // Sequencer next state
  always_comb begin
    next_s = s;
    next_s.pop = 1'b0;
    next_s.conv_start = 1'b0;

    // Serial clock falls advance the frame and shift out the next bit
    if (s.in_frame && clk_fall && s.fall_cnt < `APMS_DUAL_EDGES) begin
      next_s.fall_cnt = cnt_inc; // RULE_23
      next_s.line_first.data = frame_bit(cnt_inc, s.words.first, s.words.second); // RULE_05
      next_s.line_second.data = frame_bit(cnt_inc, s.words.second, s.words.first); // RULE_25
      if (cnt_inc == `APMS_DUAL_EDGES) begin
        next_s.line_first.oe_n = 1'b1; // RULE_07
        next_s.line_second.oe_n = 1'b1;
      end
    end

    // Sampler back to track once the conversion no longer needs it
    if (s.in_frame && clk_rise && s.fall_cnt >= `APMS_TRACK_EDGES
        && s.mode == apms_pkg::APMS_NORMAL) begin
      next_s.track = 1'b1;
    end
    // Waking from partial, the first serial clock edge releases hold
    if (s.in_frame && (clk_rise || clk_fall) && s.waking
        && s.mode == apms_pkg::APMS_PARTIAL) begin
      next_s.track = 1'b1; // RULE_18
    end

    // Select fall: sample, start both conversions, drive first zero
    if (sel_fall) begin
      next_s.in_frame = 1'b1;
      next_s.fall_cnt = '0;
      next_s.conv_start = 1'b1; // RULE_26
      next_s.track = 1'b0;
      next_s.line_first = '{data: 1'b0, oe_n: 1'b0}; // RULE_24
      next_s.line_second = '{data: 1'b0, oe_n: 1'b0};
      if (fifo_valid) begin
        next_s.words = fifo_data;
        next_s.pop = 1'b1;
      end
      if (s.mode != apms_pkg::APMS_NORMAL) begin
        next_s.waking = 1'b1; // RULE_13
        next_s.wake_from_full = (s.mode == apms_pkg::APMS_FULL);
        next_s.wake_cnt = '0;
        next_s.power_ready = 1'b0;
      end
    end

    // Select rise: end the frame and judge the fall count
    if (sel_rise && s.in_frame) begin
      next_s.in_frame = 1'b0;
      next_s.line_first.oe_n = 1'b1; // RULE_04
      next_s.line_second.oe_n = 1'b1;
      if (s.fall_cnt < `APMS_GLITCH_EDGES) begin
        // Glitch on select: mode kept, any wake-up undone
        next_s.waking = 1'b0; // RULE_10 RULE_12 RULE_13
        next_s.track = (s.mode == apms_pkg::APMS_NORMAL);
      end else if (s.fall_cnt < `APMS_KEEP_EDGES) begin
        next_s.waking = 1'b0;
        next_s.track = 1'b0;
        next_s.power_ready = 1'b0;
        if (s.mode == apms_pkg::APMS_NORMAL) begin
          next_s.mode = apms_pkg::APMS_PARTIAL; // RULE_09
        end else begin
          next_s.mode = apms_pkg::APMS_FULL; // RULE_14
        end
      end else begin
        // Ten or more falls: powered; an early rise only aborts
        next_s.mode = apms_pkg::APMS_NORMAL; // RULE_02 RULE_11
        next_s.track = 1'b1;
      end
    end

    // Wake timer; ready needs both normal mode and the elapsed delay
    if (s.waking && !sel_fall) begin
      if (s.wake_cnt >= (s.wake_from_full ? FULL_WAKE : PART_WAKE)) begin
        next_s.waking = (next_s.mode != apms_pkg::APMS_NORMAL) && next_s.waking; // RULE_11
      end else begin
        next_s.wake_cnt = s.wake_cnt + 1'b1;
      end
    end
    if (!next_s.waking && next_s.mode == apms_pkg::APMS_NORMAL) begin
      next_s.power_ready = 1'b1;
    end
  end

  // State register; mode after power-on is not defined, reset picks normal
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      s.mode <= apms_pkg::APMS_NORMAL;
      s.in_frame <= 1'b0;
      s.fall_cnt <= '0;
      s.words <= '0;
      s.line_first <= '{data: 1'b0, oe_n: 1'b1};
      s.line_second <= '{data: 1'b0, oe_n: 1'b1};
      s.pop <= 1'b0;
      s.conv_start <= 1'b0;
      s.track <= 1'b1;
      s.waking <= 1'b0;
      s.wake_from_full <= 1'b0;
      s.wake_cnt <= '0;
      s.power_ready <= 1'b1;
    end else begin
      s.mode <= next_s.mode;
      s.in_frame <= next_s.in_frame;
      s.fall_cnt <= next_s.fall_cnt;
      s.words <= next_s.words;
      s.line_first <= next_s.line_first;
      s.line_second <= next_s.line_second;
      s.pop <= next_s.pop;
      s.conv_start <= next_s.conv_start;
      s.track <= next_s.track;
      s.waking <= next_s.waking;
      s.wake_from_full <= next_s.wake_from_full;
      s.wake_cnt <= next_s.wake_cnt;
      s.power_ready <= next_s.power_ready;
    end
  end

  // Outputs straight from the state register
  assign serial_out_first_o = s.line_first;
  assign serial_out_second_o = s.line_second;
  assign conv_start_o = s.conv_start;
  assign track_o = s.track;
  assign power_mode_o = s.mode;
  assign power_ready_o = s.power_ready;

  // Checks on the sequencer's own behaviour
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n);

  AST_FLOAT_AT_32: assert property ( // RULE_07
    s.in_frame && s.fall_cnt == `APMS_DUAL_EDGES |-> s.line_first.oe_n && s.line_second.oe_n)
    else $error("line still driven after 32 falls");

  AST_GLITCH_KEEPS_MODE: assert property ( // RULE_10
    sel_rise && s.in_frame && s.fall_cnt < `APMS_GLITCH_EDGES |=> s.mode == $past(s.mode))
    else $error("early select rise changed mode");

  AST_ENTER_PARTIAL: assert property ( // RULE_09
    sel_rise && s.in_frame && s.fall_cnt >= `APMS_GLITCH_EDGES && s.fall_cnt < `APMS_KEEP_EDGES
    && s.mode == apms_pkg::APMS_NORMAL |=> s.mode == apms_pkg::APMS_PARTIAL)
    else $error("partial power-down not entered");

  AST_ENTER_FULL: assert property ( // RULE_14
    sel_rise && s.in_frame && s.fall_cnt >= `APMS_GLITCH_EDGES && s.fall_cnt < `APMS_KEEP_EDGES
    && s.mode == apms_pkg::APMS_PARTIAL |=> s.mode == apms_pkg::APMS_FULL)
    else $error("full power-down not entered");

  AST_STAY_POWERED: assert property ( // RULE_02
    sel_rise && s.in_frame && s.fall_cnt >= `APMS_KEEP_EDGES
    |=> s.mode == apms_pkg::APMS_NORMAL && s.line_first.oe_n && s.line_second.oe_n)
    else $error("late select rise did not keep power and float");

  AST_LEADING_ZERO: assert property ( // RULE_26
    sel_fall |=> !s.line_first.oe_n && !s.line_first.data && s.conv_start ##1 !s.conv_start)
    else $error("select fall did not start frame");

  AST_TRAILING_ZEROS: assert property ( // RULE_05
    s.in_frame && (s.fall_cnt == `APMS_RESULT_EDGES || s.fall_cnt == 6'h0F)
    |-> !s.line_first.data && !s.line_second.data)
    else $error("trailing bits not zero");

  AST_SECOND_HALF: assert property ( // RULE_25
    s.in_frame && s.fall_cnt == `APMS_SECOND_FIRST_EDGE
    |-> s.line_first.data == s.words.second[11] && s.line_second.data == s.words.first[11])
    else $error("second half carries wrong result");

  AST_WAKE_START: assert property ( // RULE_13
    sel_fall && s.mode == apms_pkg::APMS_PARTIAL |=> s.waking && !s.power_ready)
    else $error("wake-up not started on select fall");

endmodule : apms_sequencer

/* apms_host_model.sv */
`timescale 1ns/1ps

module apms_host_model #(
  parameter int HALF = 4,
  parameter int GAP = 6
) (
  // System clock
  input wire logic clock_i,
  // Device data lines
  input wire apms_pkg::apms_line_s serial_out_first_i,
  input wire apms_pkg::apms_line_s serial_out_second_i,
  // Host pins
  output logic conv_sel_n_o,
  output logic serial_clk_o
);
  logic [32:0] cap_d1, cap_d2, cap_z1, cap_z2;

  // Serial clock idles high and stands still between frames
  initial begin
    conv_sel_n_o = 1'b1;
    serial_clk_o = 1'b1;
  end

  // Wait whole system clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick

  // Sample both lines once k falls have been given
  // A floated line has no keeper: it reads as the inverse of its last bit
  task automatic grab(input int k);
    cap_d1[k] = serial_out_first_i.oe_n ? ~serial_out_first_i.data : serial_out_first_i.data;
    cap_z1[k] = serial_out_first_i.oe_n;
    cap_d2[k] = serial_out_second_i.oe_n ? ~serial_out_second_i.data : serial_out_second_i.data;
    cap_z2[k] = serial_out_second_i.oe_n;
  endtask : grab

  // One frame of n falls; sampling just before each next fall
  task automatic frame(input int n);
    int k;
    cap_d1 = '0;
    cap_d2 = '0;
    cap_z1 = '0;
    cap_z2 = '0;
    @(posedge clock_i);
    conv_sel_n_o <= 1'b0;
    tick(2 * HALF);
    grab(0);
    for (k = 1; k <= n; k++) begin
      serial_clk_o <= 1'b0;
      tick(HALF);
      serial_clk_o <= 1'b1;
      tick(HALF);
      grab(k);
    end
    // No trailing clocks after a power-down rise
    conv_sel_n_o <= 1'b1;
    tick(2 * HALF + GAP);
  endtask : frame
endmodule : apms_host_model

/* apms_sequencer_bench.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
  $display("unexpected at %0t got %h expected %h", $time, got, exp); end end

module apms_sequencer_bench;
  logic clock_i, rstn_i, res_valid_i, sel_n, sclk, res_ready, conv_start, track, ready;
  apms_pkg::apms_pair_s res_data_i;
  apms_pkg::apms_line_s line1, line2;
  apms_pkg::apms_mode_e mode;
  apms_pkg::apms_pair_s q [8];
  int n_fail = 0;
  int compares = 0;
  int n_start = 0;

  // Short full wake so the run stays brief
  apms_sequencer #(.FULL_WAKE_DELAY_CYC(400)) apms_sequencer_i (.clock_i(clock_i), .rstn_i(rstn_i),
    .conv_sel_n_i(sel_n), .serial_clk_i(sclk), .serial_out_first_o(line1), .serial_out_second_o(line2),
    .res_valid_i(res_valid_i), .res_ready_o(res_ready), .res_data_i(res_data_i),
    .conv_start_o(conv_start), .track_o(track), .power_mode_o(mode), .power_ready_o(ready));
  apms_host_model apms_host_model_i (.clock_i(clock_i), .serial_out_first_i(line1),
    .serial_out_second_i(line2), .conv_sel_n_o(sel_n), .serial_clk_o(sclk));

  // 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Count start pulses; a stuck pulse shows up as extra counts
  always @(posedge clock_i) begin
    if (conv_start === 1'b1) n_start <= n_start + 1;
  end

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // Offer one result pair, held until the buffer takes it
  task automatic push(input apms_pkg::apms_pair_s p);
    int i;
    @(posedge clock_i);
    res_valid_i <= 1'b1;
    res_data_i <= p;
    #1;
    for (i = 0; i < 50 && res_ready !== 1'b1; i++) @(posedge clock_i) #1;
    if (i == 50) begin
      n_fail++;
      print_verdict();
    end
    @(posedge clock_i);
    res_valid_i <= 1'b0;
  endtask : push

  // Frame then float check on both lines
  task automatic run(input int n);
    apms_host_model_i.frame(n);
    `CHK(line1.oe_n, 1'b1)
    `CHK(line2.oe_n, 1'b1)
  endtask : run

  // Captured bits against the expected frame layout
  task automatic check_frame(input apms_pkg::apms_pair_s p, input int n);
    int k;
    logic e1, e2;
    for (k = 0; k <= n; k++) begin
      e1 = 1'b0;
      e2 = 1'b0;
      if (k >= 2 && k <= 13) begin
        e1 = p.first[13 - k];
        e2 = p.second[13 - k];
      end
      if (k >= 18 && k <= 29) begin
        e1 = p.second[29 - k];
        e2 = p.first[29 - k];
      end
      `CHK(apms_host_model_i.cap_z1[k], (k == 32))
      `CHK(apms_host_model_i.cap_z2[k], (k == 32))
      if (k < 32) begin
        `CHK(apms_host_model_i.cap_d1[k], e1)
        `CHK(apms_host_model_i.cap_d2[k], e2)
      end
    end
  endtask : check_frame

  task automatic t_dual;
    int n0;
    n0 = n_start;
    push({12'hA5C, 12'h3F1});
    run(32);
    check_frame({12'hA5C, 12'h3F1}, 32);
    `CHK(n_start - n0, 1)
    $display("dual read done");
  endtask : t_dual

  task automatic t_trail;
    push({12'h9E7, 12'h168});
    run(16);
    check_frame({12'h9E7, 12'h168}, 16);
    `CHK(mode, apms_pkg::APMS_NORMAL)
    $display("trailing zeros done");
  endtask : t_trail

  task automatic t_abort;
    run(12);
    `CHK(mode, apms_pkg::APMS_NORMAL)
    run(1);
    `CHK(mode, apms_pkg::APMS_NORMAL)
    $display("abort and glitch done");
  endtask : t_abort

  // Partial, glitch, wake, partial, full, full wake
  task automatic t_power;
    int i;
    run(5);
    `CHK(mode, apms_pkg::APMS_PARTIAL)
    run(1);
    `CHK(mode, apms_pkg::APMS_PARTIAL)
    `CHK(ready, 1'b0)
    fork
      run(11);
      begin
        repeat (7) @(posedge clock_i);
        #1;
        `CHK(track, 1'b0)
        `CHK(ready, 1'b0)
        repeat (9) @(posedge clock_i);
        #1;
        `CHK(track, 1'b1)
      end
    join
    `CHK(mode, apms_pkg::APMS_NORMAL)
    `CHK(ready, 1'b1)
    run(2);
    `CHK(mode, apms_pkg::APMS_PARTIAL)
    run(9);
    `CHK(mode, apms_pkg::APMS_FULL)
    run(12);
    `CHK(ready, 1'b0)
    for (i = 0; i < 400 && ready !== 1'b1; i++) @(posedge clock_i) #1;
    `CHK(ready, 1'b1)
    `CHK((i > 200), 1'b1)
    `CHK(mode, apms_pkg::APMS_NORMAL)
    $display("power modes done");
  endtask : t_power

  // Fill the buffer until it refuses, then drain it frame by frame
  task automatic t_fifo;
    int k;
    for (k = 0; k < 8; k++) begin
      q[k] = {12'h800 | 12'(k), 12'h0F0 ^ 12'(k * 37)};
      push(q[k]);
    end
    #1;
    `CHK(res_ready, 1'b0)
    for (k = 0; k < 8; k++) begin
      run(14);
      check_frame(q[k], 14);
    end
    `CHK(res_ready, 1'b1)
    $display("buffer fill and drain done");
  endtask : t_fifo

  // Reset, one dummy cycle, then the scenarios
  initial begin
    rstn_i = 1'b0;
    res_valid_i = 1'b0;
    res_data_i = '0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (10) @(posedge clock_i);
    run(14);
    t_dual();
    t_trail();
    t_abort();
    t_power();
    t_fifo();
    print_verdict();
  end
endmodule : apms_sequencer_bench
